/* File: hdl/fcap_pkg.sv */
package fcap_pkg;
  // ***********************
  // register map (apb, own)
  // ***********************
  localparam logic [11:0] FCAP_CTRL_OFF   = 12'h000;
  localparam logic [11:0] FCAP_ADDR_OFF   = 12'h004;
  localparam logic [11:0] FCAP_WDATA_OFF  = 12'h008;
  localparam logic [11:0] FCAP_RDATA_OFF  = 12'h00C;
  localparam logic [11:0] FCAP_STATUS_OFF = 12'h010;
  localparam logic [11:0] FCAP_PINS_OFF   = 12'h014;
  localparam logic [11:0] FCAP_TIMING_OFF = 12'h018;
  // ctrl fields: go bit and command code
  localparam int FCAP_CTRL_GO_BIT   = 0;
  localparam int FCAP_CTRL_CMD_LSB  = 4;
  localparam int FCAP_CTRL_CMD_W    = 3;
  // pins fields
  localparam int FCAP_PIN_IDHV_BIT  = 0;
  localparam int FCAP_PIN_RSTHV_BIT = 1;
  localparam int FCAP_PIN_RESET_BIT = 2;
  // status fields
  localparam int FCAP_ST_BUSY_BIT   = 0;
  localparam int FCAP_ST_DONE_BIT   = 1;
  localparam int FCAP_ST_TLE_BIT    = 2;
  localparam int FCAP_ST_LOCK_BIT   = 3;
  // ***********************
  // command codes
  // ***********************
  localparam logic [2:0] FCAP_CMD_READ  = 3'h0;
  localparam logic [2:0] FCAP_CMD_WRITE = 3'h1;
  localparam logic [2:0] FCAP_CMD_IDSEQ = 3'h2;
  localparam logic [2:0] FCAP_CMD_RESET = 3'h3;
  // ***********************
  // flash command words
  // ***********************
  localparam logic [15:0] FCAP_UNLOCK1_ADDR = 16'h0555;
  localparam logic [15:0] FCAP_UNLOCK2_ADDR = 16'h02AA;
  localparam logic [7:0]  FCAP_UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0]  FCAP_UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  FCAP_IDENT_DATA   = 8'h90;
  localparam logic [7:0]  FCAP_RESET_DATA   = 8'hF0;
  localparam int          FCAP_TLE_BIT      = 5;
  // identification offsets (word mode)
  localparam logic [1:0]  FCAP_ID_MFR       = 2'b00;
  localparam logic [1:0]  FCAP_ID_DEV       = 2'b01;
  localparam logic [1:0]  FCAP_ID_PROT      = 2'b10;
  localparam int          FCAP_GUARD_BIT    = 6;
  // ***********************
  // timing
  // ***********************
  localparam int          FCAP_CLK_MHZ      = 100;
  localparam int          FCAP_PULSE_NS     = 40;
  localparam int          FCAP_PULSE_CYC    = (FCAP_PULSE_NS * FCAP_CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  FCAP_TIMING_RST   = 8'(FCAP_PULSE_CYC);
endpackage

/* File: hdl/fcap_sync.sv */
module fcap_sync
  import fcap_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_width_chk
    $error("fcap_sync: WIDTH must be positive");
  end

  // first stage read only by the second
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

/* File: hdl/fcap_tick.sv */
module fcap_tick
  import fcap_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       run_in,
  input  wire logic [7:0] period_in,
  output logic            tick_out
);
  logic [7:0] cnt_q;
  logic       tick_q;

  // one-cycle enable every period_in cycles while running
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !run_in) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else if (cnt_q + 8'h01 >= period_in) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  assign tick_out = tick_q;
endmodule

/* File: hdl/fcap_ctrl.sv */
// How it works
// R01: high-voltage id needs guard bit low
// R02: select bits pick maker, device, protection
// R03: protection read gives one or zero
// R04: command sequence gives ids without high voltage
// R05: device refuses program in protected sector
// R06: all sectors ship unprotected
// R07: protect all sectors before unprotecting
// R08: reset high voltage lifts protection temporarily
// R09: low supply ignores every write
// R10: write only with select, strobe low, oe high
// R11: power-up starts in array read
// R12: wrong sequence step returns to array read
// R13: address on late fall, data early rise
// R14: erase suspend reads array outside sectors
// R15: time-limit flag needs reset command
// R16: reset command aborts unstarted sequences
// R17: reset command ignores address bits
// R18: embedded operations end in array read
// R19: id offsets zero, one, two with sector
// R20: reset pin low aborts to array read
// R21: high-voltage detects are separate outputs
// R22: upper byte holds device identity only
//
// Added by the designer: the APB slave port and the register addresses.
module fcap_ctrl
  import fcap_pkg::*;
#(
  parameter int ADDR_W = 19
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [11:0]       paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic      [ADDR_W-1:0] fl_addr_out,
  output logic      [15:0]       fl_dq_out,
  output logic                   fl_dq_oe_out,
  input  wire logic [15:0]       fl_dq_in,
  output logic                   fl_ce_n_out,
  output logic                   fl_oe_n_out,
  output logic                   fl_we_n_out,
  output logic                   fl_reset_n_out,
  output logic                   id_voltage_address_pin_hv_out,
  output logic                   reset_pin_hv_out
);
  typedef enum logic [2:0] {FCAP_IDLE, FCAP_RD, FCAP_WR_SET, FCAP_WR_PULSE, FCAP_WR_HOLD, FCAP_NEXT} fcap_state_e;

  if (ADDR_W < 8 || ADDR_W > 24) begin : g_addr_w_chk
    $error("fcap_ctrl: ADDR_W out of range");
  end

  // ***********************
  // register state
  // ***********************
  fcap_state_e        state_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [15:0]        wdata_q;
  logic [15:0]        rdata_q;
  logic [2:0]         cmd_q;
  logic               busy_q;
  logic               done_q;
  logic               tle_q;
  logic               lock_q;
  logic [2:0]         pins_q;
  logic [7:0]         timing_q;
  logic [1:0]         step_q;
  logic [1:0]         nsteps_q;
  logic [15:0]        dq_sync;
  logic               tick;
  logic               apb_wr;
  logic               apb_rd;
  logic [ADDR_W-1:0]  step_addr;
  logic [15:0]        step_data;

  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign apb_rd = psel_in && !penable_in && !pwrite_in;

  fcap_sync #(.WIDTH(16)) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (fl_dq_in),
    .sync_out   (dq_sync)
  );

  fcap_tick u_tick (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .run_in     (busy_q && state_q != FCAP_IDLE && state_q != FCAP_NEXT),
    .period_in  (timing_q),
    .tick_out   (tick)
  );

  // ***********************
  // apb register writes
  // ***********************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      addr_q   <= '0;
      wdata_q  <= 16'h0000;
      pins_q   <= 3'b100;
      timing_q <= FCAP_TIMING_RST;
    end else if (apb_wr && !busy_q) begin
      unique case (paddr_in)
        FCAP_ADDR_OFF:   addr_q   <= pwdata_in[ADDR_W-1:0];
        FCAP_WDATA_OFF:  wdata_q  <= pwdata_in[15:0];
        FCAP_PINS_OFF:   pins_q   <= pwdata_in[2:0]; // R21 R20
        FCAP_TIMING_OFF: timing_q <= (pwdata_in[7:0] == 8'h00) ? 8'h01 : pwdata_in[7:0];
        default: ;
      endcase
    end
  end

  // ***********************
  // apb read data
  // ***********************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= 1'b0;
      if (apb_rd) begin
        unique case (paddr_in)
          FCAP_CTRL_OFF:   prdata_out <= {25'h0, cmd_q, 3'h0, busy_q};
          FCAP_ADDR_OFF:   prdata_out <= 32'(addr_q);
          FCAP_WDATA_OFF:  prdata_out <= {16'h0000, wdata_q};
          FCAP_RDATA_OFF:  prdata_out <= {16'h0000, rdata_q};
          FCAP_STATUS_OFF: prdata_out <= {28'h0, lock_q, tle_q, done_q, busy_q};
          FCAP_PINS_OFF:   prdata_out <= {29'h0, pins_q};
          FCAP_TIMING_OFF: prdata_out <= {24'h0, timing_q};
          default: begin
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b1;
          end
        endcase
      end else if (psel_in && !penable_in && !(paddr_in inside {FCAP_CTRL_OFF, FCAP_ADDR_OFF,
                   FCAP_WDATA_OFF, FCAP_STATUS_OFF, FCAP_PINS_OFF, FCAP_TIMING_OFF})) begin
        pslverr_out <= 1'b1;
      end
    end
  end

  // ***********************
  // command sequences
  // ***********************
  // id sequence: two unlocks then id command; reset: one cycle, any address
  always_comb begin
    step_addr = addr_q;
    step_data = wdata_q;
    if (cmd_q == FCAP_CMD_IDSEQ) begin // R04
      unique case (step_q)
        2'd0: begin
          step_addr = ADDR_W'(FCAP_UNLOCK1_ADDR);
          step_data = {8'h00, FCAP_UNLOCK1_DATA};
        end
        2'd1: begin
          step_addr = ADDR_W'(FCAP_UNLOCK2_ADDR);
          step_data = {8'h00, FCAP_UNLOCK2_DATA};
        end
        default: begin
          step_addr = ADDR_W'(FCAP_UNLOCK1_ADDR);
          step_data = {8'h00, FCAP_IDENT_DATA};
        end
      endcase
    end else if (cmd_q == FCAP_CMD_RESET) begin
      step_addr = addr_q; // R17
      step_data = {8'h00, FCAP_RESET_DATA}; // R15 R16
    end
  end

  // ***********************
  // bus cycle sequencer
  // ***********************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q        <= FCAP_IDLE;
      cmd_q          <= FCAP_CMD_READ;
      busy_q         <= 1'b0;
      done_q         <= 1'b0;
      tle_q          <= 1'b0;
      lock_q         <= 1'b0;
      step_q         <= 2'd0;
      nsteps_q       <= 2'd0;
      rdata_q        <= 16'h0000;
      fl_addr_out    <= '0;
      fl_dq_out      <= 16'h0000;
      fl_dq_oe_out   <= 1'b0;
      fl_ce_n_out    <= 1'b1;
      fl_oe_n_out    <= 1'b1;
      fl_we_n_out    <= 1'b1;
    end else begin
      if (apb_wr && paddr_in == FCAP_STATUS_OFF && pwdata_in[FCAP_ST_DONE_BIT]) begin
        done_q <= 1'b0;
      end
      unique case (state_q)
        FCAP_IDLE: begin
          if (apb_wr && paddr_in == FCAP_CTRL_OFF && pwdata_in[FCAP_CTRL_GO_BIT] && pins_q[FCAP_PIN_RESET_BIT]) begin
            cmd_q    <= pwdata_in[FCAP_CTRL_CMD_LSB +: FCAP_CTRL_CMD_W];
            busy_q   <= 1'b1;
            done_q   <= 1'b0;
            step_q   <= 2'd0;
            nsteps_q <= (pwdata_in[FCAP_CTRL_CMD_LSB +: FCAP_CTRL_CMD_W] == FCAP_CMD_IDSEQ) ? 2'd2 : 2'd0;
            if (pwdata_in[FCAP_CTRL_CMD_LSB +: FCAP_CTRL_CMD_W] == FCAP_CMD_READ) begin
              state_q     <= FCAP_RD;
              fl_addr_out <= addr_q; // R02
              fl_ce_n_out <= 1'b0;
              fl_oe_n_out <= 1'b0; // R10: oe low keeps reads from writing
            end else begin
              state_q     <= FCAP_WR_SET;
            end
          end
        end
        FCAP_RD: begin
          if (tick) begin
            rdata_q     <= dq_sync;
            fl_ce_n_out <= 1'b1;
            fl_oe_n_out <= 1'b1;
            state_q     <= FCAP_NEXT;
          end
        end
        FCAP_WR_SET: begin
          // address set up with oe high before the strobe falls
          fl_addr_out  <= step_addr;
          fl_dq_out    <= step_data;
          fl_dq_oe_out <= 1'b1;
          fl_oe_n_out  <= 1'b1; // R10
          // dq_oe marks a setup edge already done: one-cycle phases keep address setup
          if (tick && fl_dq_oe_out) begin
            fl_ce_n_out <= 1'b0; // R13
            fl_we_n_out <= 1'b0; // R10 R13
            state_q     <= FCAP_WR_PULSE;
          end
        end
        FCAP_WR_PULSE: begin
          if (tick) begin
            fl_we_n_out <= 1'b1; // R13: data taken on first rise
            state_q     <= FCAP_WR_HOLD;
          end
        end
        FCAP_WR_HOLD: begin
          if (tick) begin
            fl_ce_n_out  <= 1'b1;
            fl_dq_oe_out <= 1'b0;
            if (step_q < nsteps_q) begin
              step_q  <= step_q + 2'd1;
              state_q <= FCAP_WR_SET;
            end else begin
              state_q <= FCAP_NEXT;
            end
          end
        end
        FCAP_NEXT: begin
          busy_q  <= 1'b0;
          done_q  <= 1'b1;
          state_q <= FCAP_IDLE;
          if (cmd_q == FCAP_CMD_RESET) begin
            tle_q <= 1'b0; // R15
          end else if (cmd_q == FCAP_CMD_READ && rdata_q[FCAP_TLE_BIT]) begin
            tle_q <= 1'b1; // R15
          end
          if (cmd_q == FCAP_CMD_IDSEQ) begin
            lock_q <= 1'b1; // R04: device stays in id mode
          end else if (cmd_q == FCAP_CMD_RESET) begin
            lock_q <= 1'b0;
          end
        end
        default: state_q <= FCAP_IDLE;
      endcase
    end
  end

  // ***********************
  // pin outputs
  // ***********************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fl_reset_n_out                <= 1'b0;
      id_voltage_address_pin_hv_out <= 1'b0;
      reset_pin_hv_out              <= 1'b0;
    end else begin
      fl_reset_n_out                <= pins_q[FCAP_PIN_RESET_BIT]; // R20
      id_voltage_address_pin_hv_out <= pins_q[FCAP_PIN_IDHV_BIT]; // R01 R21
      reset_pin_hv_out              <= pins_q[FCAP_PIN_RSTHV_BIT]; // R08 R07
    end
  end

  // ***********************
  // checks
  // ***********************
  write_strobe_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R10
    !fl_we_n_out |-> !fl_ce_n_out && fl_oe_n_out) else $error("write strobe without ce or with oe");
  read_no_we_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R10
    !fl_oe_n_out |-> fl_we_n_out && !fl_dq_oe_out) else $error("read overlaps a write");
  addr_stable_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R13
    !fl_we_n_out |=> $stable(fl_addr_out) && $stable(fl_dq_out)) else $error("address moved in strobe");
  addr_setup_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R13
    $fell(fl_we_n_out) |-> $stable(fl_addr_out) && $stable(fl_dq_out)) else $error("address moved at strobe");
  ce_after_we_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R13
    $rose(fl_we_n_out) |-> !fl_ce_n_out) else $error("ce rose before we");
  reset_data_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R16
    $fell(fl_we_n_out) && cmd_q == FCAP_CMD_RESET |-> fl_dq_out[7:0] == FCAP_RESET_DATA)
    else $error("reset command data wrong");
  unlock_first_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R04
    $fell(fl_we_n_out) && cmd_q == FCAP_CMD_IDSEQ && step_q == 2'd0 |->
    fl_dq_out[7:0] == FCAP_UNLOCK1_DATA) else $error("id sequence first step wrong");
  tle_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R15
    state_q == FCAP_NEXT && cmd_q == FCAP_CMD_RESET |=> !tle_q && !lock_q) else $error("reset left flags");
  reset_pin_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R20
    !pins_q[FCAP_PIN_RESET_BIT] |=> !fl_reset_n_out) else $error("reset pin not driven");
  id_cov_c: cover property (@(posedge clk_sys_in) state_q == FCAP_NEXT && cmd_q == FCAP_CMD_IDSEQ);
  rd_cov_c: cover property (@(posedge clk_sys_in) state_q == FCAP_NEXT && cmd_q == FCAP_CMD_READ);
  rst_cov_c: cover property (@(posedge clk_sys_in) state_q == FCAP_NEXT && cmd_q == FCAP_CMD_RESET);
endmodule

/* File: sim/fcap_flash_model.sv */
module fcap_flash_model
  import fcap_pkg::*;
#(
  parameter logic [7:0] MFR_CODE = 8'h3C,  // arbitrary value
  parameter logic [7:0] DEV_LO   = 8'h4D,  // arbitrary value
  parameter logic [7:0] DEV_HI   = 8'h6E   // arbitrary value
) (
  input  wire logic [18:0] addr_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        reset_n_in,
  input  wire logic        id_hv_in,
  input  wire logic        rst_hv_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [15:0] prot;
  logic [1:0]  step;
  logic        prog_armed;
  logic        id_mode;
  logic [18:0] lat_addr;
  logic [15:0] rd_val;
  logic [15:0] last_val;
  wire         wr_n  = ce_n_in | we_n_in | ~oe_n_in;
  wire         rd_en = ~ce_n_in & ~oe_n_in & reset_n_in;
  wire  [10:0] a11   = lat_addr[10:0];
  wire  [7:0]  d8    = dq_in[7:0];

  initial begin
    prot = 16'h0000;
    step = 2'd0;
    prog_armed = 1'b0;
    id_mode = 1'b0;
    last_val = 16'h0000;
    foreach (mem[i]) mem[i] = 16'hFFFF;
  end

  // ************
  // write cycles
  // ************
  always @(negedge wr_n) lat_addr = addr_in;
  always @(posedge wr_n or negedge reset_n_in) begin
    if (!reset_n_in) begin
      step = 2'd0;
      prog_armed = 1'b0;
      id_mode = 1'b0;
    end else if (prog_armed) begin
      if (!prot[lat_addr[18:15]] || rst_hv_in) mem[lat_addr[7:0]] = dq_in;
      prog_armed = 1'b0;
    end else if (d8 == FCAP_RESET_DATA) begin
      step = 2'd0;
      id_mode = 1'b0;
    end else if (step == 2'd0 && a11 == FCAP_UNLOCK1_ADDR[10:0] && d8 == FCAP_UNLOCK1_DATA) step = 2'd1;
    else if (step == 2'd1 && a11 == FCAP_UNLOCK2_ADDR[10:0] && d8 == FCAP_UNLOCK2_DATA) step = 2'd2;
    else if (step == 2'd2 && a11 == FCAP_UNLOCK1_ADDR[10:0]) begin
      id_mode = (d8 == FCAP_IDENT_DATA);
      prog_armed = (d8 == 8'hA0);
      step = 2'd0;
    end else step = 2'd0;
  end

  // ***********
  // read cycles
  // ***********
  always_comb begin
    rd_val = mem[addr_in[7:0]];
    if (id_mode || (id_hv_in && !addr_in[FCAP_GUARD_BIT])) begin
      case (addr_in[1:0])
        FCAP_ID_MFR:  rd_val = {~last_val[15:8], MFR_CODE};
        FCAP_ID_DEV:  rd_val = {DEV_HI, DEV_LO};
        FCAP_ID_PROT: rd_val = {~last_val[15:8], 7'h00, prot[addr_in[18:15]]};
        default:      rd_val = ~last_val;
      endcase
    end
  end
  // released bus shows the inverted last read value: no pull on these lines
  always @(negedge rd_en) last_val = rd_val;
  assign dq_out = rd_en ? rd_val : ~last_val;
endmodule

/* File: sim/tb.sv */
module tb;
  import fcap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MFR = 8'h3C;  // arbitrary value
  localparam logic [7:0] DVL = 8'h4D;  // arbitrary value
  localparam logic [7:0] DVH = 8'h6E;  // arbitrary value
  logic        clk_sys_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic        psel_in    = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in  = 1'b0;
  logic [11:0] paddr_in   = 12'h000;
  logic [31:0] pwdata_in  = 32'h0000_0000;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, fl_dq_oe_out, fl_ce_n_out, fl_oe_n_out, fl_we_n_out, fl_reset_n_out;
  logic        id_voltage_address_pin_hv_out, reset_pin_hv_out;
  logic [18:0] fl_addr_out;
  logic [15:0] fl_dq_out, mdl_dq;
  wire  [15:0] fl_dq_in   = fl_dq_oe_out ? fl_dq_out : mdl_dq;
  int          num_errors = 0;
  int          cmp_count  = 0;
  int          seed       = 4;
  logic [15:0] shadow [0:255];
  logic [18:0] addrs [$];
  logic [18:0] a;
  logic [31:0] q;
  logic        e;

  fcap_ctrl #(.ADDR_W(19)) i_dut (.clk_sys_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .fl_addr_out, .fl_dq_out, .fl_dq_oe_out, .fl_dq_in,
    .fl_ce_n_out, .fl_oe_n_out, .fl_we_n_out, .fl_reset_n_out, .id_voltage_address_pin_hv_out, .reset_pin_hv_out);
  fcap_flash_model #(.MFR_CODE(MFR), .DEV_LO(DVL), .DEV_HI(DVH)) i_flash (.addr_in(fl_addr_out), .dq_in(fl_dq_in),
    .dq_out(mdl_dq), .ce_n_in(fl_ce_n_out), .oe_n_in(fl_oe_n_out), .we_n_in(fl_we_n_out),
    .reset_n_in(fl_reset_n_out), .id_hv_in(id_voltage_address_pin_hv_out), .rst_hv_in(reset_pin_hv_out));

  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // *****************
  // checks and verdict
  // *****************
  task automatic fail(input string m);
    num_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk(input string m, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [31:0] id_exp(input int k);
    case (k)
      0:       return {24'h00_0000, MFR};
      1:       return {16'h0000, DVH, DVL};
      default: return 32'h0000_0000;  // no sector ever protected here
    endcase
  endfunction
  function automatic logic [31:0] id_mask(input int k);
    return (k == 1) ? 32'h0000_FFFF : 32'h0000_00FF;
  endfunction

  // *********
  // bus tasks
  // *********
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= ad;
    pwdata_in  <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    // this wait ends when pready_out is high; the watchdog catches a hang
    do begin
      @(posedge clk_sys_in);
    end while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, FCAP_STATUS_OFF, 32'h0000_0000);
      n++;
    end while (q[FCAP_ST_DONE_BIT] !== 1'b1 && n < 100);
    if (q[FCAP_ST_DONE_BIT] !== 1'b1) fail("done missing");
  endtask
  task automatic go(input logic [2:0] c);
    apb(1'b1, FCAP_CTRL_OFF, (32'(c) << FCAP_CTRL_CMD_LSB) | 32'h0000_0001);
    wait_done;
  endtask
  task automatic fwr(input logic [18:0] ad, input logic [15:0] d);
    apb(1'b1, FCAP_ADDR_OFF, 32'(ad));
    apb(1'b1, FCAP_WDATA_OFF, 32'(d));
    go(FCAP_CMD_WRITE);
  endtask
  task automatic frd(input logic [18:0] ad);
    apb(1'b1, FCAP_ADDR_OFF, 32'(ad));
    go(FCAP_CMD_READ);
    apb(1'b0, FCAP_RDATA_OFF, 32'h0000_0000);
  endtask
  task automatic prog(input logic [18:0] ad, input logic [15:0] d);
    fwr(19'(FCAP_UNLOCK1_ADDR), 16'(FCAP_UNLOCK1_DATA));
    fwr(19'(FCAP_UNLOCK2_ADDR), 16'(FCAP_UNLOCK2_DATA));
    fwr(19'(FCAP_UNLOCK1_ADDR), 16'h00A0);
    fwr(ad, d);
    shadow[ad[7:0]] = d;
  endtask

  always @(posedge clk_sys_in) begin
    if (!rst_in && fl_we_n_out === 1'b0 &&
        (fl_ce_n_out !== 1'b0 || fl_oe_n_out !== 1'b1 || fl_dq_oe_out !== 1'b1)) fail("strobes");
  end

  initial begin
    #500_000;
    fail("timeout");
    print_verdict;
  end

  initial begin
    foreach (shadow[i]) shadow[i] = 16'hFFFF;
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    apb(1'b0, FCAP_STATUS_OFF, 32'h0000_0000);
    chk("status rst", q, 32'h0000_0000);
    apb(1'b0, FCAP_TIMING_OFF, 32'h0000_0000);
    chk("timing rst", q, 32'(FCAP_TIMING_RST));
    apb(1'b0, FCAP_PINS_OFF, 32'h0000_0000);
    chk("pins rst", q, 32'h0000_0004);
    chk("flash rst", 32'(fl_reset_n_out), 32'h0000_0001);
    apb(1'b1, 12'h01C, 32'h0000_0000);
    chk("unmapped", 32'(e), 32'h0000_0001);
    apb(1'b1, FCAP_RDATA_OFF, 32'h0000_0000);
    chk("rdata ro", 32'(e), 32'h0000_0001);
    // longer phases keep the block busy across the next bus write
    apb(1'b1, FCAP_TIMING_OFF, 32'h0000_0008);
    prog(19'h7_FFFF, 16'h0000);
    addrs.push_back(19'h7_FFFF);
    repeat (5) begin
      a = 19'($random(seed));
      prog(a, 16'($random(seed)) & 16'hFFDF);  // time-limit bit kept clear
      addrs.push_back(a);
    end
    foreach (addrs[i]) begin
      frd(addrs[i]);
      chk("array", q & 32'h0000_FFFF, 32'(shadow[addrs[i][7:0]]));
    end
    go(FCAP_CMD_IDSEQ);
    apb(1'b0, FCAP_STATUS_OFF, 32'h0000_0000);
    chk("idmode", 32'(q[FCAP_ST_LOCK_BIT]), 32'h0000_0001);
    for (int k = 0; k < 3; k++) begin
      frd(19'h1_8000 | 19'(k));
      chk("id code", q & id_mask(k), id_exp(k));
    end
    apb(1'b1, FCAP_ADDR_OFF, 32'($random(seed)) & 32'h0007_FFFF);
    apb(1'b1, FCAP_CTRL_OFF, (32'(FCAP_CMD_RESET) << FCAP_CTRL_CMD_LSB) | 32'h0000_0001);
    wait_done;
    apb(1'b0, FCAP_STATUS_OFF, 32'h0000_0000);
    chk("idmode off", 32'(q[FCAP_ST_LOCK_BIT]), 32'h0000_0000);
    frd(addrs[0]);
    chk("array again", q & 32'h0000_FFFF, 32'(shadow[addrs[0][7:0]]));
    apb(1'b1, FCAP_PINS_OFF, 32'h0000_0005);
    apb(1'b0, FCAP_PINS_OFF, 32'h0000_0000);
    chk("id hv pin", 32'(id_voltage_address_pin_hv_out), 32'h0000_0001);
    frd(19'h0_0001);
    chk("hv dev", q & 32'h0000_00FF, 32'(DVL));
    frd(19'h0_0041);
    chk("hv guard", q & 32'h0000_FFFF, 32'(shadow[8'h41]));
    apb(1'b1, FCAP_PINS_OFF, 32'h0000_0006);
    apb(1'b0, FCAP_PINS_OFF, 32'h0000_0000);
    chk("rst hv pin", 32'({reset_pin_hv_out, id_voltage_address_pin_hv_out}), 32'h0000_0002);
    apb(1'b1, FCAP_PINS_OFF, 32'h0000_0004);
    // earlier id and blank reads may have set the flag: start clean
    go(FCAP_CMD_RESET);
    prog(19'h0_0033, 16'h0020);
    frd(19'h0_0033);
    apb(1'b0, FCAP_STATUS_OFF, 32'h0000_0000);
    chk("tle set", 32'(q[FCAP_ST_TLE_BIT]), 32'h0000_0001);
    go(FCAP_CMD_RESET);
    apb(1'b0, FCAP_STATUS_OFF, 32'h0000_0000);
    chk("tle clear", 32'(q[FCAP_ST_TLE_BIT]), 32'h0000_0000);
    apb(1'b1, FCAP_STATUS_OFF, 32'h0000_0002);
    apb(1'b1, FCAP_PINS_OFF, 32'h0000_0000);
    apb(1'b0, FCAP_PINS_OFF, 32'h0000_0000);
    chk("flash rst low", 32'(fl_reset_n_out), 32'h0000_0000);
    apb(1'b1, FCAP_CTRL_OFF, 32'h0000_0001);
    apb(1'b0, FCAP_STATUS_OFF, 32'h0000_0000);
    chk("go refused", q & 32'h0000_0003, 32'h0000_0000);
    apb(1'b1, FCAP_PINS_OFF, 32'h0000_0004);
    apb(1'b1, FCAP_ADDR_OFF, 32'h0000_0011);
    apb(1'b1, FCAP_CTRL_OFF, (32'(FCAP_CMD_READ) << FCAP_CTRL_CMD_LSB) | 32'h0000_0001);
    apb(1'b1, FCAP_ADDR_OFF, 32'h0000_0022);
    wait_done;
    apb(1'b0, FCAP_ADDR_OFF, 32'h0000_0000);
    chk("addr busy", q, 32'h0000_0011);
    print_verdict;
  end
endmodule
